// ==== design/tac_sequencer.sv ====
`timescale 1ns/10ps
module tac_sequencer import tac_pkg::*; (
  input wire logic ref_clk,           // 40 MHz clock
  input wire logic rst,               // sync reset, active high
  input wire tac_cfg_s cfg,           // host configuration
  input wire logic cmd_start,         // pulse: host wrote scan select
  input wire logic hw_pd,             // hardware power-down
  input wire logic touch_sense,       // panel comparator, 1 = touched
  input wire tac_adc_s adc,           // converter result and done
  input wire logic rd_strobe,         // pulse: host read a result
  input wire logic [3:0] rd_index,    // result read by host
  output logic pen_or_data_ready_n,   // pen / data-ready pin
  output logic ctrl_mode_status,      // readable control mode
  output logic int_clk_en,            // internal clock running
  output logic pen_det_en,            // touch detect circuit enabled
  output logic drv_y,                 // Y panel drivers
  output logic drv_x,                 // X panel drivers
  output logic drv_z,                 // pressure drivers
  output logic adc_power,             // converter powered
  output logic adc_start,             // pulse: start conversion
  output logic [3:0] adc_chan,        // converter input select
  output logic batt_div_en,           // battery divider on
  output logic temp_high_current,     // diode bias raised for second read
  output logic set_done,              // pulse: set stored
  output tac_res_t result             // result registers
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETTLE, ST_CONV, ST_WAIT, ST_STORE, ST_PRECHG, ST_SENSE
  } tac_state_e;

  tac_state_e state;           // sequencer state
  tac_chan_e chan;             // channel in progress
  logic [15:0] cnt;            // wait counter
  logic [14:0] acc;            // averaging sum
  logic [3:0] nsamp;           // samples taken
  logic [3:0] run_sel;         // scan latched at start
  logic [3:0] drv_hold;        // host-held driver command
  logic [8:0] unread;          // results stored but not yet read
  logic pen_lat;               // touch seen, waiting for set end
  logic pen_det;               // qualified touch event
  logic coord_sel;             // scan select is a coordinate scan
  logic start_ok;              // a scan may begin now
  tac_chan_e nxt;              // channel after the current one
  logic [3:0] need;            // samples wanted

  // detector is cut off during measurement to keep pull-up current off the panel
  assign pen_det = touch_sense && !hw_pd && state == ST_IDLE && drv_hold == SC_NONE;
  assign coord_sel = cfg.scan_sel inside {SC_XY, SC_XYZ, SC_X, SC_Y, SC_Z};
  // self mode starts on touch, host mode on a write; others need host mode
  assign start_ok = cfg.host_ctrl
    ? (cmd_start && cfg.scan_sel inside {[SC_XY:SC_PORT]})
    : (pen_det && coord_sel);
  assign nxt = next_chan(run_sel, chan);
  assign need = 4'(1 << cfg.avg_log2);

  // main sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      chan <= CH_END;
      cnt <= 16'h0000;
      acc <= 15'h0000;
      nsamp <= 4'h0;
      run_sel <= SC_NONE;
      set_done <= 1'b0;
    end else begin
      set_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_ok) begin
            run_sel <= cfg.scan_sel;
            chan <= next_chan(cfg.scan_sel, CH_END);
            cnt <= 16'(cfg.stab * STAB_UNIT_CYC);
            state <= ST_SETTLE;
          end
        end
        // drivers on, panel settles
        ST_SETTLE: begin
          if (cnt == 16'h0000) begin
            acc <= 15'h0000;
            nsamp <= 4'h0;
            state <= ST_CONV;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        ST_CONV: state <= ST_WAIT;
        // gather samples for averaging
        ST_WAIT: begin
          if (adc.done) begin
            acc <= acc + 15'(adc.data);
            nsamp <= nsamp + 4'h1;
            state <= (nsamp + 4'h1 == need) ? ST_STORE : ST_CONV;
          end
        end
        ST_STORE: begin
          if (nxt == CH_END) begin
            if (run_sel == SC_AUX_SCAN && cfg.scan_sel == SC_AUX_SCAN && cfg.host_ctrl) begin
              cnt <= 16'(cfg.stab * STAB_UNIT_CYC);
              state <= ST_SETTLE;
            end else begin
              set_done <= 1'b1;
              state <= ST_IDLE;
            end
          end else if (nxt <= CH_Z2) begin
            chan <= nxt;
            cnt <= 16'(cfg.prechg * PS_UNIT_CYC);
            state <= ST_PRECHG;
          end else begin
            chan <= nxt;
            cnt <= 16'(cfg.stab * STAB_UNIT_CYC);
            state <= ST_SETTLE;
          end
        end
        // charge panel capacitance before the touch recheck
        ST_PRECHG: begin
          if (cnt == 16'h0000) begin
            cnt <= 16'(cfg.sense * PS_UNIT_CYC);
            state <= ST_SENSE;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        ST_SENSE: begin
          if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
          end else if (touch_sense) begin
            cnt <= 16'(cfg.stab * STAB_UNIT_CYC);
            state <= ST_SETTLE;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // result registers, averaged sum shifted down
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result <= {9{RES_RST}};
    end else if (state == ST_STORE && chan != CH_END) begin
      result[chan] <= 12'(acc >> cfg.avg_log2);
    end
  end

  // host stepping: driver-only commands hold drivers until next write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drv_hold <= SC_NONE;
    end else if (cmd_start && cfg.host_ctrl) begin
      drv_hold <= (cfg.scan_sel >= SC_DRV_X) ? cfg.scan_sel : SC_NONE;
    end
  end

  // converter and panel controls, one cycle behind the state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drv_y <= 1'b0;
      drv_x <= 1'b0;
      drv_z <= 1'b0;
      adc_power <= 1'b0;
      adc_start <= 1'b0;
      adc_chan <= 4'h0;
      batt_div_en <= 1'b0;
      temp_high_current <= 1'b0;
      int_clk_en <= 1'b0;
      pen_det_en <= 1'b0;
      ctrl_mode_status <= 1'b0;
    end else begin
      drv_y <= (state inside {ST_SETTLE, ST_CONV, ST_WAIT} && chan == CH_Y)
               || drv_hold == SC_DRV_Y;
      drv_x <= (state inside {ST_SETTLE, ST_CONV, ST_WAIT} && chan == CH_X)
               || drv_hold == SC_DRV_X;
      drv_z <= (state inside {ST_SETTLE, ST_CONV, ST_WAIT} && chan inside {CH_Z1, CH_Z2})
               || drv_hold == SC_DRV_Z;
      adc_power <= state inside {ST_CONV, ST_WAIT};
      adc_start <= state == ST_CONV;
      adc_chan <= chan;
      // divider draws current, so it is on only around the battery sample
      batt_div_en <= state inside {ST_CONV, ST_WAIT} && chan inside {CH_BA, CH_BB};
      temp_high_current <= state != ST_IDLE && chan == CH_T2;
      int_clk_en <= state != ST_IDLE;
      pen_det_en <= !hw_pd && state == ST_IDLE;
      ctrl_mode_status <= cfg.host_ctrl;
    end
  end

  // touch latch and unread tracking; a new event wins over a clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pen_lat <= 1'b0;
      unread <= 9'h000;
    end else begin
      pen_lat <= pen_det || (pen_lat && !set_done);
      if (set_done) begin
        unread <= set_mask(run_sel);
      end else if (rd_strobe && rd_index < 4'h9) begin
        unread[rd_index] <= 1'b0;
      end
    end
  end

  // pen / data-ready pin
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pen_or_data_ready_n <= 1'b1;
    end else begin
      case (cfg.pin_fn)
        FN_PEN: pen_or_data_ready_n <= !pen_det;
        FN_DAV: pen_or_data_ready_n <= unread == 9'h000;
        default: pen_or_data_ready_n <= !pen_lat;
      endcase
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  pen_pin_low_a: assert property (cfg.pin_fn == FN_PEN && pen_det |=> !pen_or_data_ready_n)
    else $error("pen touch did not lower pin");
  dav_low_a: assert property (cfg.pin_fn == FN_DAV && set_done && $stable(cfg.pin_fn)
    |-> ##2 !pen_or_data_ready_n)
    else $error("data ready not signalled");
  dav_release_a: assert property (cfg.pin_fn == FN_DAV && unread == 9'h000
    |=> pen_or_data_ready_n)
    else $error("pin low with nothing unread");
  // the latch sits between touch and pin, so the pin follows two edges later
  both_pin_a: assert property (cfg.pin_fn[1] && pen_det ##1 cfg.pin_fn[1]
    |=> !pen_or_data_ready_n)
    else $error("touch missed in combined mode");
  pd_detect_a: assert property (hw_pd |=> !pen_det_en)
    else $error("detector enabled in power-down");
  // status is forced low in reset, so the edge after reset is left out
  mode_echo_a: assert property (!$past(rst)
    |-> ctrl_mode_status == $past(cfg.host_ctrl))
    else $error("mode status wrong");
  self_start_a: assert property (!cfg.host_ctrl && state == ST_IDLE && pen_det && coord_sel
    |-> ##2 int_clk_en)
    else $error("clock not started on touch");
  host_only_a: assert property (state == ST_IDLE && !cfg.host_ctrl
    |=> state == ST_IDLE || chan <= CH_Z2)
    else $error("non-touch scan in self mode");
  batt_div_a: assert property (batt_div_en |-> $past(chan == CH_BA || chan == CH_BB))
    else $error("divider on outside battery sample");
  untouched_end_a: assert property (state == ST_SENSE && cnt == 16'h0000 && !touch_sense
    |=> state == ST_IDLE ##1 !set_done)
    else $error("scan continued without touch");

  xyz_done_c: cover property (run_sel == SC_XYZ && set_done);
  port_done_c: cover property (run_sel == SC_PORT && set_done);
  temp_diff_c: cover property (temp_high_current && adc_start);
  aux_loop_c: cover property (run_sel == SC_AUX_SCAN && state == ST_STORE ##1 state == ST_SETTLE);
endmodule // tac_sequencer

// ==== design/tac_pkg.sv ====
// What this block does
// - function 00: pin is pen-touch interrupt only
// - function 01: pin low when set stored
// - data mode: pin high once set read
// - functions 1x: low on touch, high after set
// - hardware power-down disables touch detection
// - control mode from config, echoed in status
// - self mode: touch lowers pin, starts clock
// - Y: drivers, settle, convert, average, store
// - still touched: same sequence for X
// - pressure selected: two pressure conversions stored
// - host writes scan select; device times it
// - temperature only in host-controlled mode
// - differential temperature: second, higher-current conversion
// - battery only in host-controlled mode
// - battery divider on only while sampling
// - auxiliary only in host-controlled mode
// - auxiliary scan converts continuously, refreshing result
// - port scan converts both batteries and auxiliary
// - port scan only in host-controlled mode
// - reset restores all registers and counters
// - pin function from two-bit config field
// - precharge then sense before touch recheck
package tac_pkg;
  // pin function codes; 10 and 11 behave alike
  localparam logic [1:0] FN_PEN = 2'h0;
  localparam logic [1:0] FN_DAV = 2'h1;
  // scan select codes
  localparam logic [3:0] SC_NONE = 4'h0;
  localparam logic [3:0] SC_XY = 4'h1;
  localparam logic [3:0] SC_XYZ = 4'h2;
  localparam logic [3:0] SC_X = 4'h3;
  localparam logic [3:0] SC_Y = 4'h4;
  localparam logic [3:0] SC_Z = 4'h5;
  localparam logic [3:0] SC_BAT_A = 4'h6;
  localparam logic [3:0] SC_BAT_B = 4'h7;
  localparam logic [3:0] SC_AUX = 4'h8;
  localparam logic [3:0] SC_AUX_SCAN = 4'h9;
  localparam logic [3:0] SC_TEMP = 4'hA;
  localparam logic [3:0] SC_TEMP_DIFF = 4'hB;
  localparam logic [3:0] SC_PORT = 4'hC;
  localparam logic [3:0] SC_DRV_X = 4'hD;
  localparam logic [3:0] SC_DRV_Y = 4'hE;
  localparam logic [3:0] SC_DRV_Z = 4'hF;
  // timing: units of the programmable wait fields
  localparam int CLK_NS = 25;
  localparam int STAB_UNIT_NS = 1000;
  localparam int PS_UNIT_NS = 500;
  localparam int STAB_UNIT_CYC = (STAB_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PS_UNIT_CYC = (PS_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [11:0] RES_RST = 12'h000;
  // result channels, also result register index
  typedef enum logic [3:0] {
    CH_Y, CH_X, CH_Z1, CH_Z2, CH_BA, CH_BB, CH_AUX, CH_T1, CH_T2, CH_END
  } tac_chan_e;
  // host-written configuration
  typedef struct packed {
    logic host_ctrl;       // 1: host-controlled converter
    logic [3:0] scan_sel;  // scan function
    logic [1:0] pin_fn;    // pen/data-ready function
    logic [1:0] avg_log2;  // 1,2,4,8 samples
    logic [7:0] stab;      // panel stabilization, STAB units
    logic [2:0] prechg;    // precharge, PS units
    logic [2:0] sense;     // sense, PS units
  } tac_cfg_s;
  // converter answer
  typedef struct packed {
    logic done;
    logic [11:0] data;
  } tac_adc_s;
  typedef logic [8:0][11:0] tac_res_t;

  // next channel of a scan; CH_END as cur gives the first
  function automatic tac_chan_e next_chan(logic [3:0] sel, tac_chan_e cur);
    tac_chan_e n;
    n = CH_END;
    case (sel)
      SC_XY: n = (cur == CH_END) ? CH_Y : (cur == CH_Y) ? CH_X : CH_END;
      SC_XYZ: begin
        case (cur)
          CH_END: n = CH_Y;
          CH_Y: n = CH_X;
          CH_X: n = CH_Z1;
          CH_Z1: n = CH_Z2;
          default: n = CH_END;
        endcase
      end
      SC_X: n = (cur == CH_END) ? CH_X : CH_END;
      SC_Y: n = (cur == CH_END) ? CH_Y : CH_END;
      SC_Z: n = (cur == CH_END) ? CH_Z1 : (cur == CH_Z1) ? CH_Z2 : CH_END;
      SC_BAT_A: n = (cur == CH_END) ? CH_BA : CH_END;
      SC_BAT_B: n = (cur == CH_END) ? CH_BB : CH_END;
      SC_AUX, SC_AUX_SCAN: n = (cur == CH_END) ? CH_AUX : CH_END;
      SC_TEMP: n = (cur == CH_END) ? CH_T1 : CH_END;
      SC_TEMP_DIFF: n = (cur == CH_END) ? CH_T1 : (cur == CH_T1) ? CH_T2 : CH_END;
      SC_PORT: begin
        case (cur)
          CH_END: n = CH_BA;
          CH_BA: n = CH_BB;
          CH_BB: n = CH_AUX;
          default: n = CH_END;
        endcase
      end
      default: n = CH_END;
    endcase
    return n;
  endfunction

  // result registers written by one full scan
  function automatic logic [8:0] set_mask(logic [3:0] sel);
    logic [8:0] m;
    tac_chan_e c;
    m = 9'h000;
    c = next_chan(sel, CH_END);
    for (int i = 0; i < 4; i++) begin
      if (c != CH_END) begin
        m[c] = 1'b1;
        c = next_chan(sel, c);
      end
    end
    return m;
  endfunction
endpackage

// ==== verification/tac_adc_model.sv ====
`timescale 1ns/10ps
module tac_adc_model import tac_pkg::*; (
  input wire logic ref_clk,        // 40 MHz clock
  input wire logic rst,            // sync reset, active high
  input wire logic adc_start,      // pulse: start conversion
  input wire logic [3:0] adc_chan, // input select
  input wire logic slow,           // 1: long conversions
  output tac_adc_s adc             // result and done
);
  logic [4:0] cnt;    // cycles left, 0 when idle
  logic [3:0] chan_q; // channel held from start
  // conversion timer; a start while busy is dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt <= 5'h00;
      chan_q <= 4'h0;
    end else if (adc_start && cnt == 5'h00) begin
      cnt <= slow ? 5'h14 : 5'h03;
      chan_q <= adc_chan;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end
  end
  // data flips outside done so a stale sample never matches
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      adc.done <= 1'b0;
      adc.data <= 12'hA5A;
    end else begin
      adc.done <= (cnt == 5'h01);
      adc.data <= (cnt == 5'h01) ? {chan_q, 8'h5A} : ~adc.data;
    end
  end
endmodule // tac_adc_model

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
module tb_top import tac_pkg::*;;
  logic ref_clk, rst, cmd_start, hw_pd, touch_sense, rd_strobe, slow; // stimulus
  tac_cfg_s cfg; // host configuration
  tac_adc_s adc; // converter answer
  logic [3:0] rd_index, adc_chan, hc_chan; // read index, channel, high-bias channel
  logic pin_n, mode_st, clk_en, det_en, dy, dx, dz, pwr, adc_start, bdiv, thc, set_done;
  tac_res_t result; // result registers
  int fails = 0, total_checks = 0, n_done = 0, n_aux = 0, bad_div = 0, done0 = 0, aux0 = 0;
  // scan codes that self mode must refuse, four bits each
  localparam logic [15:0] REFUSED_CODES = {SC_PORT, SC_AUX, SC_BAT_A, SC_TEMP};
  tac_sequencer tac_sequencer_i (.ref_clk(ref_clk), .rst(rst), .cfg(cfg),
    .cmd_start(cmd_start), .hw_pd(hw_pd), .touch_sense(touch_sense), .adc(adc),
    .rd_strobe(rd_strobe), .rd_index(rd_index), .pen_or_data_ready_n(pin_n),
    .ctrl_mode_status(mode_st), .int_clk_en(clk_en), .pen_det_en(det_en), .drv_y(dy),
    .drv_x(dx), .drv_z(dz), .adc_power(pwr), .adc_start(adc_start), .adc_chan(adc_chan),
    .batt_div_en(bdiv), .temp_high_current(thc), .set_done(set_done), .result(result));
  tac_adc_model tac_adc_model_i (.ref_clk(ref_clk), .rst(rst), .adc_start(adc_start),
    .adc_chan(adc_chan), .slow(slow), .adc(adc));
  // free running clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // event counters watched by the scenarios
  always @(posedge ref_clk) begin
    if (set_done === 1'b1) n_done <= n_done + 1;
    if (adc_start === 1'b1 && adc_chan == 4'(CH_AUX)) n_aux <= n_aux + 1;
    if (rst === 1'b1) hc_chan <= 4'hF;
    else if (adc_start === 1'b1 && thc === 1'b1) hc_chan <= adc_chan;
    if (bdiv === 1'b1 && adc_chan != 4'(CH_BA) && adc_chan != 4'(CH_BB)) bad_div <= bad_div + 1;
  end
  // expected converter value of a channel
  function automatic logic [11:0] ev(input tac_chan_e c);
    return {4'(c), 8'h5A};
  endfunction
  task automatic chk_res(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: result %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  // settle-sampled waits; bounded so a hang shows as a mismatch
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_done();
    int k0;
    int i;
    k0 = n_done;
    for (i = 0; i < 3000 && n_done == k0; i++) tick(1);
    chk_bit(n_done != k0, 1'b1);
  endtask
  task automatic wait_start(input tac_chan_e c);
    int i;
    for (i = 0; i < 3000 && !(adc_start === 1'b1 && adc_chan == 4'(c)); i++) tick(1);
    chk_bit(adc_start, 1'b1);
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
  endtask
  // host writes a scan code, one-cycle start pulse
  task automatic host_cmd(input logic [3:0] code);
    @(posedge ref_clk);
    cfg.scan_sel <= code;
    cmd_start <= 1'b1;
    @(posedge ref_clk);
    cmd_start <= 1'b0;
  endtask
  task automatic rd(input tac_chan_e c);
    @(posedge ref_clk);
    rd_strobe <= 1'b1;
    rd_index <= 4'(c);
    @(posedge ref_clk);
    rd_strobe <= 1'b0;
  endtask
  task automatic touch(input logic t);
    @(posedge ref_clk);
    touch_sense <= t;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, well beyond the longest run
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    rst <= 1'b1;
    cmd_start <= 1'b0;
    hw_pd <= 1'b0;
    touch_sense <= 1'b0;
    rd_strobe <= 1'b0;
    rd_index <= 4'h0;
    slow <= 1'b1;
    cfg <= '{host_ctrl: 1'b0, scan_sel: SC_XYZ, pin_fn: 2'h2, avg_log2: 2'h1,
      stab: 8'h01, prechg: 3'h1, sense: 3'h1};
    do_reset();
    tick(1);
    chk_bit(pin_n, 1'b1);
    for (int i = 0; i < 9; i++) chk_res(result[i], RES_RST);
    // self mode XYZ with averaging, touch lifted during pressure
    touch(1'b1);
    tick(4);
    chk_bit(pin_n, 1'b0);
    chk_bit(clk_en, 1'b1);
    chk_bit(dy, 1'b1);
    // each pressure read is preceded by a touch recheck, so lift after the last one starts
    wait_start(CH_Z2);
    chk_bit(pwr, 1'b1);
    chk_bit(dz, 1'b1);
    touch(1'b0);
    tick(1);
    chk_bit(pin_n, 1'b0);
    wait_done();
    for (int c = 0; c < 4; c++) chk_res(result[c], ev(tac_chan_e'(c)));
    tick(3);
    chk_bit(pin_n, 1'b1);
    // reset after the scan ends, then touch lost after Y: X never converted
    do_reset();
    slow <= 1'b0;
    cfg.avg_log2 <= 2'h0;
    cfg.scan_sel <= SC_XY;
    tick(1);
    chk_res(result[CH_Z2], RES_RST);
    done0 = n_done;
    touch(1'b1);
    wait_start(CH_Y);
    touch(1'b0);
    tick(300);
    chk_bit(n_done == done0, 1'b1);
    chk_res(result[CH_Y], ev(CH_Y));
    chk_res(result[CH_X], RES_RST);
    // self mode refuses non-coordinate codes
    cfg.pin_fn <= FN_PEN;
    cfg.scan_sel <= SC_TEMP;
    touch(1'b1);
    for (int k = 0; k < 4; k++) begin
      cfg.scan_sel <= REFUSED_CODES[4*k +: 4];
      tick(100);
      chk_bit(clk_en, 1'b0);
      chk_bit(pin_n, 1'b0);
    end
    touch(1'b0);
    // power-down hides touches
    hw_pd <= 1'b1;
    touch(1'b1);
    tick(5);
    chk_bit(pin_n, 1'b1);
    chk_bit(det_en, 1'b0);
    touch(1'b0);
    hw_pd <= 1'b0;
    // host port scan, data-ready held until whole set read
    cfg.host_ctrl <= 1'b1;
    cfg.pin_fn <= FN_DAV;
    host_cmd(SC_PORT);
    wait_done();
    chk_bit(mode_st, 1'b1);
    tick(3);
    chk_bit(pin_n, 1'b0);
    chk_res(result[CH_BA], ev(CH_BA));
    chk_res(result[CH_BB], ev(CH_BB));
    chk_res(result[CH_AUX], ev(CH_AUX));
    rd(CH_BA);
    rd(CH_BB);
    tick(3);
    chk_bit(pin_n, 1'b0);
    rd(CH_AUX);
    tick(3);
    chk_bit(pin_n, 1'b1);
    chk_bit(bad_div == 0, 1'b1);
    // differential temperature
    host_cmd(SC_TEMP_DIFF);
    wait_done();
    chk_res(result[CH_T1], ev(CH_T1));
    chk_res(result[CH_T2], ev(CH_T2));
    chk_bit(hc_chan == 4'(CH_T2), 1'b1);
    // host steps: drivers only, then a conversion command
    host_cmd(SC_DRV_X);
    tick(4);
    chk_bit(dx, 1'b1);
    host_cmd(SC_X);
    wait_done();
    chk_res(result[CH_X], ev(CH_X));
    // continuous auxiliary scan
    // the loop never ends a set while still selected, so count conversions instead
    aux0 = n_aux;
    host_cmd(SC_AUX_SCAN);
    tick(200);
    chk_bit(n_aux - aux0 >= 2, 1'b1);
    cfg.scan_sel <= SC_NONE;
    wait_done();
    chk_res(result[CH_AUX], ev(CH_AUX));
    tick(200);
    tally_and_finish();
  end
endmodule // tb_top
